/* File: hdl/aux_conv_pkg.sv */
// Purpose: constants for the channel 1 input setup and auxiliary converter control registers
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   shared by the register bank and its sequencer
package aux_conv_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] REG_RECORD_CH1_INPUT_SETUP = 8'h50;
    localparam logic [7:0] REG_AUX_CONVERTER_CONTROL  = 8'h51;
    localparam logic [7:0] RESET_RECORD_CH1_INPUT_SETUP = 8'h00;
    localparam logic [7:0] RESET_AUX_CONVERTER_CONTROL  = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int POS_CH1_INPUT_SOURCE    = 6;
    localparam int POS_CH1_INPUT_IMPEDANCE = 4;
    localparam int POS_CH1_CM_TOLERANCE    = 2;
    localparam int POS_CH1_FULL_SCALE      = 1;
    localparam int POS_CH1_BANDWIDTH       = 0;
    localparam int POS_AUX_ENABLE          = 7;
    localparam int POS_AUX_MODE            = 5;
    localparam int POS_SINGLE_START        = 4;
    localparam int POS_REPEAT_STOP         = 3;
    localparam int POS_SINGLE_DONE         = 2;

    // ************************************************************
    // encodings
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_DIFFERENTIAL = 2'h0,
        SRC_SINGLE_ENDED = 2'h1,
        SRC_MUX_POSITIVE = 2'h2,
        SRC_MUX_NEGATIVE = 2'h3
    } input_source_e;

    typedef enum logic [1:0] {
        IMP_5K  = 2'h0,
        IMP_10K = 2'h1,
        IMP_40K = 2'h2,
        IMP_RSV = 2'h3
    } impedance_e;

    typedef enum logic [1:0] {
        CM_AC_LOW   = 2'h0,
        CM_MEDIUM   = 2'h1,
        CM_RAIL     = 2'h2,
        CM_RSV      = 2'h3
    } cm_tolerance_e;

    typedef enum logic [1:0] {
        MODE_SINGLE_ONE  = 2'h0,
        MODE_SINGLE_MULTI = 2'h1,
        MODE_REPEAT_ONE  = 2'h2,
        MODE_REPEAT_MULTI = 2'h3
    } aux_mode_e;

    // converter sequencer states
    typedef enum logic [1:0] {
        CONV_IDLE   = 2'h0,
        CONV_SINGLE = 2'h1,
        CONV_REPEAT = 2'h2
    } conv_state_e;

    // cycles one conversion takes in the sequencer model
    localparam logic [7:0] CONV_CYCLES = 8'h20;

endpackage

/* File: hdl/aux_conv_sequencer.sv */
// Purpose: steps the auxiliary converter through single and repeated conversions
// Assumes: conversion length fixed by CONV_CYCLES
// Notes:   start is a level from the register bank, held until busy is seen, dropped when disabled or in a repeat mode
`timescale 1ns/100ps
module aux_conv_sequencer (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    // control
    input  wire logic                        enable,
    input  wire aux_conv_pkg::aux_mode_e     mode,
    input  wire logic                        start,
    input  wire logic                        stop,
    // status
    output logic                             busy,
    output logic                             sample_strobe,
    output logic                             single_finished
);
    import aux_conv_pkg::*;

    conv_state_e state;
    logic [7:0]  count;
    logic        repeat_mode;
    logic        last;

    assign repeat_mode = mode[1];
    assign last        = (count == CONV_CYCLES - 8'h01);
    assign busy        = (state != CONV_IDLE);

    // ************************************************************
    // state machine
    // ************************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= CONV_IDLE;
        end else if (!enable) begin
            state <= CONV_IDLE;
        end else begin
            unique case (state)
                CONV_IDLE: begin
                    if (start && !repeat_mode) begin
                        state <= CONV_SINGLE;
                    end else if (repeat_mode && !stop) begin
                        state <= CONV_REPEAT;
                    end
                end
                CONV_SINGLE: begin
                    if (last) begin
                        state <= CONV_IDLE;
                    end
                end
                CONV_REPEAT: begin
                    // stop takes effect at the end of the running conversion
                    if (last && (stop || !repeat_mode)) begin
                        state <= CONV_IDLE;
                    end
                end
                default: begin
                    state <= CONV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count <= 8'h00;
        end else if (state == CONV_IDLE || last) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sample_strobe   <= 1'b0;
            single_finished <= 1'b0;
        end else begin
            sample_strobe   <= enable && busy && last;
            single_finished <= enable && (state == CONV_SINGLE) && last;
        end
    end

endmodule

/* File: hdl/aux_conv_regs.sv */
// Purpose: channel 1 input setup and auxiliary converter control register bank
// Assumes: simple synchronous register port from the control interface
// Notes:   reads are combinational, writes take effect at the next edge
`timescale 1ns/100ps
module aux_conv_regs (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          reset,
    // register port
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_write,
    input  wire logic [7:0]                    reg_wdata,
    output logic      [7:0]                    reg_rdata,
    output logic                               reg_hit,
    // channel 1 analog setup
    output aux_conv_pkg::input_source_e        ch1_input_source,
    output aux_conv_pkg::impedance_e           ch1_input_impedance,
    output aux_conv_pkg::cm_tolerance_e        ch1_common_mode_tolerance,
    output logic                               ch1_full_scale_select,
    output logic                               ch1_bandwidth_select,
    output logic                               ch1_use_positive_pin,
    output logic                               ch1_use_negative_pin,
    // auxiliary converter
    output logic                               aux_conv_enable,
    output aux_conv_pkg::aux_mode_e            aux_conv_mode,
    output logic                               aux_conv_multi_channel,
    output logic                               aux_conv_busy,
    output logic                               aux_conv_sample_strobe,
    output logic                               single_conv_done_flag
);
    import aux_conv_pkg::*;

    logic [7:0] setup;
    logic       single_conv_start;
    logic       repeat_conv_stop;
    logic       start_pulse;
    logic       single_finished;
    logic       write_setup;
    logic       write_aux;

    assign write_setup = reg_write && (reg_addr == REG_RECORD_CH1_INPUT_SETUP);
    assign write_aux   = reg_write && (reg_addr == REG_AUX_CONVERTER_CONTROL);

    // ************************************************************
    // channel 1 input setup
    // ************************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            setup <= RESET_RECORD_CH1_INPUT_SETUP;
        end else if (write_setup) begin
            setup <= reg_wdata;
        end
    end

    assign ch1_input_source          = input_source_e'(setup[POS_CH1_INPUT_SOURCE +: 2]);
    assign ch1_input_impedance       = impedance_e'(setup[POS_CH1_INPUT_IMPEDANCE +: 2]);
    assign ch1_common_mode_tolerance = cm_tolerance_e'(setup[POS_CH1_CM_TOLERANCE +: 2]);
    assign ch1_full_scale_select     = setup[POS_CH1_FULL_SCALE];
    assign ch1_bandwidth_select      = setup[POS_CH1_BANDWIDTH];
    // pin steering; differential uses both pins
    assign ch1_use_positive_pin = (ch1_input_source != SRC_MUX_NEGATIVE);
    assign ch1_use_negative_pin = (ch1_input_source == SRC_DIFFERENTIAL)
                               || (ch1_input_source == SRC_MUX_NEGATIVE);

    // ************************************************************
    // auxiliary converter control
    // ************************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            aux_conv_enable  <= RESET_AUX_CONVERTER_CONTROL[POS_AUX_ENABLE];
            aux_conv_mode    <= MODE_SINGLE_ONE;
            repeat_conv_stop <= RESET_AUX_CONVERTER_CONTROL[POS_REPEAT_STOP];
        end else if (write_aux) begin
            aux_conv_enable  <= reg_wdata[POS_AUX_ENABLE];
            aux_conv_mode    <= aux_mode_e'(reg_wdata[POS_AUX_MODE +: 2]);
            repeat_conv_stop <= reg_wdata[POS_REPEAT_STOP];
        end
    end

    // single-channel modes follow the source mux
    assign aux_conv_multi_channel = aux_conv_mode[0];

    assign start_pulse = write_aux && reg_wdata[POS_SINGLE_START];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            single_conv_start <= 1'b0;
        end else if (start_pulse) begin
            single_conv_start <= 1'b1;
        end else if (aux_conv_busy || !aux_conv_enable || aux_conv_mode[1]) begin
            // sequential modes ignore a start; a kept bit would fire later in one-shot
            single_conv_start <= 1'b0;
        end
    end

    // done flag; completion beats a same-cycle start
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            single_conv_done_flag <= 1'b0;
        end else if (single_finished) begin
            single_conv_done_flag <= 1'b1;
        end else if (start_pulse) begin
            single_conv_done_flag <= 1'b0;
        end
    end

    aux_conv_sequencer sequencer (
        .core_clk        (core_clk),
        .reset           (reset),
        .enable          (aux_conv_enable),
        .mode            (aux_conv_mode),
        .start           (single_conv_start),
        .stop            (repeat_conv_stop),
        .busy            (aux_conv_busy),
        .sample_strobe   (aux_conv_sample_strobe),
        .single_finished (single_finished)
    );

    // ************************************************************
    // read back
    // ************************************************************
    always_comb begin
        reg_rdata = 8'h00;
        reg_hit   = 1'b1;
        unique case (reg_addr)
            REG_RECORD_CH1_INPUT_SETUP: begin
                reg_rdata = setup;
            end
            REG_AUX_CONVERTER_CONTROL: begin
                reg_rdata = {aux_conv_enable, aux_conv_mode, single_conv_start,
                             repeat_conv_stop, single_conv_done_flag, 2'h0};
            end
            default: begin
                reg_hit = 1'b0;
            end
        endcase
    end

endmodule

/* File: testbench/aux_conv_regs_monitor.sv */
// Purpose: port checker for the channel setup and aux converter bank
// Assumes: one clock, async reset high
// Notes:   bound to every aux_conv_regs
`timescale 1ns/100ps
module aux_conv_regs_monitor (
    // clock and reset
    input wire logic                          core_clk,
    input wire logic                          reset,
    // register port
    input wire logic [7:0]                    reg_addr,
    input wire logic                          reg_write,
    input wire logic [7:0]                    reg_wdata,
    input wire logic [7:0]                    reg_rdata,
    input wire logic                          reg_hit,
    // channel 1 setup
    input wire aux_conv_pkg::input_source_e   ch1_input_source,
    input wire aux_conv_pkg::impedance_e      ch1_input_impedance,
    input wire aux_conv_pkg::cm_tolerance_e   ch1_common_mode_tolerance,
    input wire logic                          ch1_full_scale_select,
    input wire logic                          ch1_bandwidth_select,
    // converter
    input wire logic                          aux_conv_enable,
    input wire aux_conv_pkg::aux_mode_e       aux_conv_mode,
    input wire logic                          aux_conv_multi_channel,
    input wire logic                          aux_conv_busy,
    input wire logic                          aux_conv_sample_strobe,
    input wire logic                          single_conv_done_flag
);
    import aux_conv_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // ********************************
    // write sequences
    // ********************************
    sequence s_setup_wr;
        reg_write && reg_addr == REG_RECORD_CH1_INPUT_SETUP;
    endsequence
    sequence s_aux_wr;
        reg_write && reg_addr == REG_AUX_CONVERTER_CONTROL;
    endsequence
    sequence s_start;
        s_aux_wr ##0 reg_wdata[7:4] == 4'h9;
    endsequence
    // ********************************
    // properties
    // ********************************
    a_setup_fields: assert property (s_setup_wr |=>
        {ch1_input_source, ch1_input_impedance, ch1_common_mode_tolerance,
         ch1_full_scale_select, ch1_bandwidth_select} == $past(reg_wdata))
        else $error("setup fields differ from written byte");
    a_aux_fields: assert property (s_aux_wr |=> aux_conv_enable == $past(reg_wdata[7])
        && aux_conv_mode == $past(reg_wdata[6:5])) else $error("aux fields wrong");
    a_aux_readback: assert property (reg_addr == REG_AUX_CONVERTER_CONTROL |->
        reg_rdata[7:5] == {aux_conv_enable, aux_conv_mode}
        && reg_rdata[2:0] == {single_conv_done_flag, 2'h0}) else $error("aux read wrong");
    a_unmapped_zero: assert property (!reg_hit |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_single_source: assert property (aux_conv_multi_channel ==
        (aux_conv_mode inside {MODE_SINGLE_MULTI, MODE_REPEAT_MULTI}))
        else $error("channel source decode wrong");
    a_start_runs: assert property (s_start ##0 !aux_conv_busy |=> ##[0:2] aux_conv_busy)
        else $error("start did not begin conversion");
    a_done_clears: assert property (s_start ##0 single_conv_done_flag |=>
        !single_conv_done_flag) else $error("done kept over new start");
    a_done_strobe: assert property ($rose(single_conv_done_flag) |->
        $past(aux_conv_sample_strobe) && !$past(aux_conv_busy))
        else $error("done without finish");
    a_stop_halts: assert property (s_aux_wr ##0 reg_wdata[3] |-> ##[1:36] !aux_conv_busy)
        else $error("stop did not idle converter");
endmodule
bind aux_conv_regs aux_conv_regs_monitor u_mon (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .ch1_input_source(ch1_input_source),
    .ch1_input_impedance(ch1_input_impedance),
    .ch1_common_mode_tolerance(ch1_common_mode_tolerance),
    .ch1_full_scale_select(ch1_full_scale_select), .ch1_bandwidth_select(ch1_bandwidth_select),
    .aux_conv_enable(aux_conv_enable), .aux_conv_mode(aux_conv_mode),
    .aux_conv_multi_channel(aux_conv_multi_channel), .aux_conv_busy(aux_conv_busy),
    .aux_conv_sample_strobe(aux_conv_sample_strobe),
    .single_conv_done_flag(single_conv_done_flag));

/* File: testbench/aux_conv_regs_bench.sv */
// Purpose: self-checking bench for the setup and aux converter bank
// Assumes: 50 MHz clock, reset high for 5 cycles
// Notes:   conversion timing derived from CONV_CYCLES
`timescale 1ns/100ps
`define CHECK_EQ(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
    fail_count++; $display("MISMATCH %s exp %h got %h", what, exp, got); end end
module aux_conv_regs_bench;
    import aux_conv_pkg::*;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_s;
    logic          core_clk  = 1'b0;
    logic          reset     = 1'b1;
    logic [7:0]    reg_addr  = 8'h00;
    logic          reg_write = 1'b0;
    logic [7:0]    reg_wdata = 8'h00;
    logic [7:0]    reg_rdata;
    logic          reg_hit;
    input_source_e ch1_input_source;
    impedance_e    ch1_input_impedance;
    cm_tolerance_e ch1_common_mode_tolerance;
    aux_mode_e     aux_conv_mode;
    logic          full_scale, bandwidth, use_pos, use_neg, enable, multi, busy, strobe, done;
    logic [1:0]    pins;
    logic [7:0]    fields;
    int            fail_count = 0;
    int            n_compared = 0;
    int            n;
    // legal software settings plus writes to unmapped 0x4F and 0x52; 0x44 tries the read-only done bit
    // 0x6A: 4 Vrms only with audio band and rail tolerance
    // 0xA5: wide band only with 40k impedance
    row_s rows[9] = '{'{8'h50, 8'h6A, 8'h6A}, '{8'h50, 8'hA5, 8'hA5}, '{8'h50, 8'hE0, 8'hE0},
        '{8'h50, 8'h18, 8'h18}, '{8'h51, 8'h60, 8'h60}, '{8'h51, 8'h28, 8'h28},
        '{8'h51, 8'h44, 8'h40}, '{8'h4F, 8'hFF, 8'h00}, '{8'h52, 8'hFF, 8'h00}};

    aux_conv_regs dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .ch1_input_source(ch1_input_source), .ch1_input_impedance(ch1_input_impedance),
        .ch1_common_mode_tolerance(ch1_common_mode_tolerance),
        .ch1_full_scale_select(full_scale), .ch1_bandwidth_select(bandwidth),
        .ch1_use_positive_pin(use_pos), .ch1_use_negative_pin(use_neg),
        .aux_conv_enable(enable), .aux_conv_mode(aux_conv_mode),
        .aux_conv_multi_channel(multi), .aux_conv_busy(busy),
        .aux_conv_sample_strobe(strobe), .single_conv_done_flag(done));

    always #10 core_clk = ~core_clk;

    // ********************************
    // bus and wait helpers
    // ********************************
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        #1;
        `CHECK_EQ("reg_rdata", e, reg_rdata)
    endtask
    function logic flag_of(input int w);
        case (w)
            0: return busy;
            1: return done;
            2: return strobe;
            default: return !busy;
        endcase
    endfunction
    // bounded wait; n returns the cycles spent
    task wait_on(input int w, input int lim);
        n = 0;
        while (flag_of(w) !== 1'b1) begin
            if (n == lim) begin
                fail_count++;
                $display("MISMATCH wait %0d exp 1 got 0", w);
                test_done();
            end
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        rd(REG_RECORD_CH1_INPUT_SETUP, RESET_RECORD_CH1_INPUT_SETUP);
        rd(REG_AUX_CONVERTER_CONTROL, RESET_AUX_CONVERTER_CONTROL);
        `CHECK_EQ("pins", 2'h3, {use_pos, use_neg})
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].exp);
            `CHECK_EQ("hit", rows[i].addr inside {8'h50, 8'h51}, reg_hit)
            fields = {ch1_input_source, ch1_input_impedance, ch1_common_mode_tolerance,
                      full_scale, bandwidth};
            if (rows[i].addr == 8'h50) `CHECK_EQ("fields", rows[i].exp, fields)
            if (rows[i].addr == 8'h51)
                `CHECK_EQ("ctl", rows[i].wdata[7:5], {enable, aux_conv_mode})
            pins = {rows[i].wdata[7:6] != 2'h3, rows[i].wdata[7:6] inside {2'h0, 2'h3}};
            if (rows[i].addr == 8'h50) `CHECK_EQ("pins", pins, {use_pos, use_neg})
            if (rows[i].addr == 8'h51) `CHECK_EQ("multi", rows[i].wdata[5], multi)
        end
        wr(REG_AUX_CONVERTER_CONTROL, 8'h80);
        repeat (3) @(posedge core_clk);
        `CHECK_EQ("busy idle", 1'b0, busy)
        wr(REG_AUX_CONVERTER_CONTROL, 8'h90);
        `CHECK_EQ("start read", 8'h90, reg_rdata)
        wait_on(0, 4);
        wait_on(3, 40);
        `CHECK_EQ("busy length", CONV_CYCLES, 8'(n))
        wait_on(1, 3);
        rd(REG_AUX_CONVERTER_CONTROL, 8'h84);
        wr(REG_AUX_CONVERTER_CONTROL, 8'h90);
        `CHECK_EQ("done cleared", 1'b0, done)
        wait_on(0, 4);
        repeat (5) @(posedge core_clk);
        reset <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHECK_EQ("reset mid run", 10'h000, {busy, done, reg_rdata})
        @(posedge core_clk);
        reset <= 1'b0;
        wr(REG_AUX_CONVERTER_CONTROL, 8'hC0);
        wait_on(2, 40);
        @(posedge core_clk);
        #1;
        wait_on(2, 40);
        `CHECK_EQ("strobe spacing", CONV_CYCLES, 8'(n + 1))
        wr(REG_AUX_CONVERTER_CONTROL, 8'hC8);
        wait_on(3, 40);
        repeat (40) begin
            @(posedge core_clk);
            #1;
            `CHECK_EQ("stopped strobe", 1'b0, strobe)
        end
        wr(REG_AUX_CONVERTER_CONTROL, 8'hD8);
        rd(REG_AUX_CONVERTER_CONTROL, 8'hC8);
        wr(REG_AUX_CONVERTER_CONTROL, 8'h80);
        @(posedge core_clk);
        #1;
        `CHECK_EQ("stale start", 1'b0, busy)
        wr(REG_AUX_CONVERTER_CONTROL, 8'hC0);
        wait_on(0, 4);
        wr(REG_AUX_CONVERTER_CONTROL, 8'h40);
        @(posedge core_clk);
        #1;
        `CHECK_EQ("disabled busy", 1'b0, busy)
        test_done();
    end
endmodule
